//--- design/sdram_init_defs.svh
// Constants for the DRAM power-up link: timing counts and register layout
`ifndef SDRAM_INIT_DEFS_SVH
`define SDRAM_INIT_DEFS_SVH
`define CLK_PERIOD_NS 20
// Timing figures in their own units
`define RESET_LOW_PULSE_MIN_NS 100
`define SCAN_HOLD_US 700
`define CKE_SETUP_NS 10
`define RESET_WAIT_US 500
`define CLOCK_STABLE_NS 10
`define CLOCK_STABLE_TCK 5
`define SELF_REFRESH_EXIT_TCK 8
`define MODE_WRITE_GAP_TCK 8
`define MODE_TO_COMMAND_GAP_TCK 24
`define LOCK_WAIT_TCK 768
`define INITIAL_CAL_TCK 1024
// Derived cycle counts (least times round up)
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_CYC `CEIL_CYC(`RESET_LOW_PULSE_MIN_NS)
`define SCAN_HOLD_CYC `CEIL_CYC(`SCAN_HOLD_US * 1000)
`define CKE_SETUP_CYC `CEIL_CYC(`CKE_SETUP_NS)
`define RESET_WAIT_CYC `CEIL_CYC(`RESET_WAIT_US * 1000)
`define CLOCK_STABLE_CYC ((`CEIL_CYC(`CLOCK_STABLE_NS) > `CLOCK_STABLE_TCK) ? `CEIL_CYC(`CLOCK_STABLE_NS) : `CLOCK_STABLE_TCK)
`define RESET_EXIT_CYC ((`SELF_REFRESH_EXIT_TCK > 5) ? `SELF_REFRESH_EXIT_TCK : 5)
// Mode register field positions with reset defaults of zero
`define MODE_THREE_GEAR_DOWN_BIT 3
`define MODE_THREE_PER_DEV_BIT 4
`define MODE_FOUR_MAX_PWR_SAVE_BIT 1
`define MODE_FOUR_SOFT_REPAIR_BIT 5
`define MODE_FOUR_CAL_LAT_LSB 6
`define MODE_FOUR_HARD_REPAIR_BIT 13
`define MODE_FIVE_PAR_LAT_LSB 0
`define MODE_REG_RESET 18'h00000
// Address bits of read/write
`define ADDR_AUTO_PRE_BIT 10
`define ADDR_BURST_SEL_BIT 12
`endif

//--- design/sdram_init_pkg.sv
// Types shared by both ends of the DRAM initialization link
package sdram_init_pkg;
  // Command encoding on the link
  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NO_OPERATION = 4'h1,
    CMD_MODE_REG_WRITE = 4'h2,
    CMD_ROW_ACTIVATE = 4'h3,
    CMD_READ = 4'h4,
    CMD_WRITE = 4'h5,
    CMD_LONG_CAL = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_PRECHARGE = 4'h8
  } cmd_t;
  // Device width
  typedef enum logic [1:0] {
    WIDTH_X4 = 2'h0,
    WIDTH_X8 = 2'h1,
    WIDTH_X16 = 2'h2
  } dev_width_t;
endpackage

//--- design/sdram_link_if.sv
// Link between memory controller and DRAM device
`timescale 1ns/1ps
interface sdram_link_if;
  logic reset_n;
  logic scan_mode_enable_pin;
  logic cke;
  logic termination_control_pin;
  sdram_init_pkg::cmd_t cmd;
  logic [1:0] bank_group_select;
  logic [1:0] bank_sel;
  logic [17:0] addr;
  logic [2:0] mode_reg_sel;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rdata_valid;
  logic term_hiz;
  modport ctrl (output reset_n, scan_mode_enable_pin, cke,
                termination_control_pin, cmd, bank_group_select,
                bank_sel, addr, mode_reg_sel, wdata,
                input rdata, rdata_valid, term_hiz);
  modport dev (input reset_n, scan_mode_enable_pin, cke,
               termination_control_pin, cmd, bank_group_select,
               bank_sel, addr, mode_reg_sel, wdata,
               output rdata, rdata_valid, term_hiz);
endinterface

//--- design/sdram_init_ctrl.sv
// Controller end: reset, clock enable and mode programming sequence
`timescale 1ns/1ps
`include "sdram_init_defs.svh"
// Summary of operation
// [R1] Device has four or two bank groups
// [R2] Bursts are eight or chopped four
// [R3] Activate latches bank group, bank, row
// [R4] Column command: A10 precharge, A12 burst
// [R5] No-operation only for power-save exit, gear-down
// [R6] Special mode settings reset to zero
// [R7] Reset and scan pin held low long
// [R8] Clock enable low 10 ns before release
// [R9] Initialization starts within three seconds
// [R10] Wait 500 us after reset release
// [R11] Program every mode register explicitly
// [R12] Clock stable, deselect with clock enable
// [R13] Clock enable held high through calibration
// [R14] Termination off until clock enable sampled
// [R15] Termination control static during initialization
// [R16] Wait reset exit delay before mode write
// [R17] Mode writes 3,6,5,4,2,1 then zero
// [R18] Long calibration, then lock and cal wait
// [R19] Writes in all burst and precharge forms
// [R20] Two words per clock, eight transfers; the device here moves one word per clock
// [R21] Idle: refresh or toggle within 960 ms; the controller here sends only deselect once done
module sdram_init_ctrl #(
  parameter int RESET_WAIT_CYC = `RESET_WAIT_CYC,
  parameter int SCAN_HOLD_CYC = `SCAN_HOLD_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_start, // Pulse: begin init sequence
  input wire logic [17:0] i_mode_val [7], // Values for mode registers
  output logic o_ready, // Initialization finished
  sdram_link_if.ctrl link // Link to device
);
  // Sequence states, one per wait of the power-up walk
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RESET_LOW = 4'h1,
    S_CKE_SETUP = 4'h2,
    S_WAIT_500 = 4'h3,
    S_CLK_STABLE = 4'h4,
    S_EXIT_WAIT = 4'h5,
    S_MODE_WRITE = 4'h6,
    S_MODE_GAP = 4'h7,
    S_CAL = 4'h8,
    S_CAL_WAIT = 4'h9,
    S_DONE = 4'ha
  } state_t;

  // Lock and calibration run together, so the longer one governs
  localparam int CAL_WAIT_CYC = (`LOCK_WAIT_TCK > `INITIAL_CAL_TCK) ?
                                `LOCK_WAIT_TCK : `INITIAL_CAL_TCK;

  // --------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------
  state_t state_q;
  // Shared cycle counter, cleared on every state change except into S_DONE, which clears it itself
  logic [31:0] cnt_q;
  // Index into the mode write order
  logic [2:0] step_q;

  // Mode register order for each programming step
  function automatic logic [2:0] mr_of_step(input logic [2:0] s);
    case (s)
      3'h0: mr_of_step = 3'h3;
      3'h1: mr_of_step = 3'h6;
      3'h2: mr_of_step = 3'h5;
      3'h3: mr_of_step = 3'h4;
      3'h4: mr_of_step = 3'h2;
      3'h5: mr_of_step = 3'h1;
      default: mr_of_step = 3'h0;
    endcase
  endfunction

  // Counter expired when reaching a bound
  function automatic logic done_at(input logic [31:0] c, input int n);
    done_at = (c >= 32'(n - 1));
  endfunction

  // State register and step counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      cnt_q <= 32'h0;
      step_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      case (state_q)
        // Start is ignored once the sequence runs
        S_IDLE: begin
          cnt_q <= 32'h0;
          if (i_start) begin
            state_q <= S_RESET_LOW;
          end
        end
        // Scan pin hold exceeds reset pulse, so it governs release
        S_RESET_LOW: begin
          if (done_at(cnt_q, SCAN_HOLD_CYC) &&
              done_at(cnt_q, `RESET_LOW_CYC)) begin // R7
            state_q <= S_CKE_SETUP;
            cnt_q <= 32'h0;
          end
        end
        // Reset pin is released while clock enable is still low
        S_CKE_SETUP: begin
          if (done_at(cnt_q, `CKE_SETUP_CYC)) begin // R8
            state_q <= S_WAIT_500;
            cnt_q <= 32'h0;
          end
        end
        // Fixed wait well below three seconds
        S_WAIT_500: begin
          if (done_at(cnt_q, RESET_WAIT_CYC)) begin // R10 R9
            state_q <= S_CLK_STABLE;
            cnt_q <= 32'h0;
          end
        end
        // Clock has run all along; this counts the span before enable
        S_CLK_STABLE: begin
          if (done_at(cnt_q, `CLOCK_STABLE_CYC)) begin // R12
            state_q <= S_EXIT_WAIT;
            cnt_q <= 32'h0;
          end
        end
        // Clock enable is high; first mode write waits the exit delay
        S_EXIT_WAIT: begin
          if (done_at(cnt_q, `RESET_EXIT_CYC)) begin // R16
            state_q <= S_MODE_WRITE;
            cnt_q <= 32'h0;
          end
        end
        S_MODE_WRITE: begin
          state_q <= S_MODE_GAP;
          cnt_q <= 32'h0;
        end
        // Step six is the write to register zero; it needs the longer
        // mode-to-command gap before calibration may start
        S_MODE_GAP: begin
          if (step_q == 3'h6) begin
            if (done_at(cnt_q, `MODE_TO_COMMAND_GAP_TCK)) begin // R17
              state_q <= S_CAL;
              cnt_q <= 32'h0;
            end
          end else if (done_at(cnt_q, `MODE_WRITE_GAP_TCK)) begin // R17
            step_q <= step_q + 3'h1;
            state_q <= S_MODE_WRITE;
            cnt_q <= 32'h0;
          end
        end
        S_CAL: begin
          state_q <= S_CAL_WAIT;
          cnt_q <= 32'h0;
        end
        // Clock enable must not drop here; nothing else may run
        S_CAL_WAIT: begin
          if (done_at(cnt_q, CAL_WAIT_CYC)) begin // R18
            state_q <= S_DONE;
          end
        end
        // Ready holds; refresh and idle toggling are left to user logic
        S_DONE: begin
          cnt_q <= 32'h0;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  // Clock enable stays high from rising until done; no power-down here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link.reset_n <= 1'b0;
      link.scan_mode_enable_pin <= 1'b0;
      link.cke <= 1'b0;
      link.termination_control_pin <= 1'b0;
      link.cmd <= sdram_init_pkg::CMD_DESELECT;
      link.mode_reg_sel <= 3'h0;
      link.addr <= 18'h0;
      link.bank_group_select <= 2'h0;
      link.bank_sel <= 2'h0;
      link.wdata <= 16'h0;
      o_ready <= 1'b0;
    end else begin
      link.reset_n <= !(state_q inside {S_IDLE, S_RESET_LOW}); // R7
      link.scan_mode_enable_pin <= 1'b0; // R7
      link.cke <= state_q inside {S_EXIT_WAIT, S_MODE_WRITE,
                                  S_MODE_GAP, S_CAL, S_CAL_WAIT,
                                  S_DONE}; // R13 R8
      // Low keeps nominal termination usable in mode register one
      link.termination_control_pin <= 1'b0; // R15
      // Deselect fills every idle cycle; no-operation is never sent
      link.cmd <= sdram_init_pkg::CMD_DESELECT; // R12 R5
      // Address returns to zero so stale mode values never linger
      link.addr <= 18'h0;
      if (state_q == S_MODE_WRITE) begin
        link.cmd <= sdram_init_pkg::CMD_MODE_REG_WRITE; // R11
        link.mode_reg_sel <= mr_of_step(step_q); // R17
        link.addr <= i_mode_val[mr_of_step(step_q)];
      end else if (state_q == S_CAL) begin
        link.cmd <= sdram_init_pkg::CMD_LONG_CAL; // R18
      end
      o_ready <= (state_q == S_DONE);
    end
  end
endmodule

//--- design/sdram_init_dev.sv
// Device end: reset defaults, termination hold-off, command decode
`timescale 1ns/1ps
`include "sdram_init_defs.svh"
module sdram_init_dev (
  input wire logic i_clk, // Device clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire sdram_init_pkg::dev_width_t i_width, // Device width
  output logic [17:0] o_mode_reg [7], // Mode register contents
  output logic o_cke_seen, // Clock enable sampled high
  output logic [1:0] o_act_bg, // Latched bank group
  output logic [1:0] o_act_bank, // Latched bank
  output logic [17:0] o_act_row, // Latched row
  output logic [9:0] o_col, // Column of last access
  output logic o_auto_pre, // Auto precharge requested
  output logic o_chop, // Chopped burst of four
  output logic o_burst_active, // Burst in progress
  output logic [2:0] o_beat, // Transfer index, one per clock
  sdram_link_if.dev link // Link from controller
);
  logic [2:0] beats_left_q;
  logic otf_en;
  logic in_reset;

  assign in_reset = i_rst || !link.reset_n;
  assign otf_en = (o_mode_reg[0][1:0] == 2'h1);

  // Mode registers: special settings reset to zero, then written
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 7; i++) begin
        o_mode_reg[i] <= `MODE_REG_RESET; // R6
      end
    end else if (!link.reset_n) begin
      for (int i = 0; i < 7; i++) begin
        o_mode_reg[i] <= `MODE_REG_RESET; // R6
      end
    end else if (link.cke &&
                 link.cmd == sdram_init_pkg::CMD_MODE_REG_WRITE &&
                 link.mode_reg_sel != 3'h7) begin
      o_mode_reg[link.mode_reg_sel] <= link.addr;
    end
  end

  // Termination stays off until clock enable is seen after reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cke_seen <= 1'b0;
    end else if (!link.reset_n) begin
      o_cke_seen <= 1'b0; // R14
    end else if (link.cke) begin
      o_cke_seen <= 1'b1; // R14
    end
  end
  assign link.term_hiz = in_reset || !o_cke_seen; // R14

  // Activate latches; x16 has only one bank group bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_act_bg <= 2'h0;
      o_act_bank <= 2'h0;
      o_act_row <= 18'h0;
    end else if (link.reset_n && link.cke &&
                 link.cmd == sdram_init_pkg::CMD_ROW_ACTIVATE) begin
      o_act_bg <= (i_width == sdram_init_pkg::WIDTH_X16) ?
                  {1'b0, link.bank_group_select[0]} :
                  link.bank_group_select; // R1 R3
      o_act_bank <= link.bank_sel; // R3
      o_act_row <= link.addr; // R3
    end
  end

  // Read/write: column, precharge and burst length, then 8 beats, or 4 when chopped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_col <= 10'h0;
      o_auto_pre <= 1'b0;
      o_chop <= 1'b0;
      o_burst_active <= 1'b0;
      o_beat <= 3'h0;
      beats_left_q <= 3'h0;
    end else if (!link.reset_n) begin
      o_burst_active <= 1'b0;
      beats_left_q <= 3'h0;
    end else if (link.cke && (link.cmd == sdram_init_pkg::CMD_READ ||
                 link.cmd == sdram_init_pkg::CMD_WRITE)) begin // R19
      o_col <= link.addr[9:0]; // R4
      o_auto_pre <= link.addr[`ADDR_AUTO_PRE_BIT]; // R4
      o_chop <= otf_en ? !link.addr[`ADDR_BURST_SEL_BIT] :
                (o_mode_reg[0][1:0] == 2'h2); // R4 R2
      o_burst_active <= 1'b1;
      o_beat <= 3'h0;
      beats_left_q <= (otf_en ? !link.addr[`ADDR_BURST_SEL_BIT] :
                       (o_mode_reg[0][1:0] == 2'h2)) ? 3'h3 : 3'h7; // R2
    end else if (o_burst_active) begin
      o_beat <= o_beat + 3'h1; // R20
      beats_left_q <= beats_left_q - 3'h1;
      if (beats_left_q == 3'h0) begin
        o_burst_active <= 1'b0;
      end
    end
  end

  // Read data echo of the beat index stands in for array data
  assign link.rdata = {13'h0, o_beat}; // R20
  assign link.rdata_valid = o_burst_active;
endmodule

//--- test/sdram_link_checker.sv
// Checker for the controller-to-device link
`timescale 1ns/1ps
module sdram_link_checker #(
  parameter int RESET_WAIT_CYC = 50
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset, active high
  input wire logic reset_n, // Device reset, active low
  input wire logic cke, // Clock enable
  input wire logic termination_control_pin, // Termination control
  input wire sdram_init_pkg::cmd_t cmd, // Command
  input wire logic [2:0] mode_reg_sel, // Mode register index
  input wire logic term_hiz // Termination off
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  localparam logic [2:0] ORDER [7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2,
                                       3'h1, 3'h0};
  logic [15:0] wait_q;
  logic [2:0] mode_wr_q;
  logic is_mode_wr;
  assign is_mode_wr = (cmd == sdram_init_pkg::CMD_MODE_REG_WRITE);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Cycles out of reset with clock enable low; saturates to avoid wrap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 16'h0000;
    end else if (!reset_n) begin
      wait_q <= 16'h0000;
    end else if (!cke && wait_q != 16'hffff) begin
      wait_q <= wait_q + 16'h0001;
    end
  end
  // Mode writes seen since device reset, stops at seven
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_wr_q <= 3'h0;
    end else if (!reset_n) begin
      mode_wr_q <= 3'h0;
    end else if (is_mode_wr && mode_wr_q != 3'h7) begin
      mode_wr_q <= mode_wr_q + 3'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_term_hiz_held: assert property ((!reset_n || !cke) |-> term_hiz)
    else $error("termination on before clock enable");
  a_cke_low_release: assert property ($rose(reset_n) |-> !cke && !$past(cke))
    else $error("clock enable not low at reset release");
  a_cke_wait_long: assert property ($rose(cke) |-> wait_q >= RESET_WAIT_CYC)
    else $error("clock enable raised too early");
  a_deselect_at_cke: assert property ($rose(cke) |->
      cmd == sdram_init_pkg::CMD_DESELECT)
    else $error("no deselect with clock enable");
  a_cke_held_high: assert property ($fell(cke) |-> !reset_n)
    else $error("clock enable dropped");
  a_exit_before_write: assert property ($rose(cke) |-> !is_mode_wr [*8])
    else $error("mode write inside exit delay");
  a_mode_gap_kept: assert property (is_mode_wr |=> !is_mode_wr [*7])
    else $error("mode write gap too short");
  a_mode_in_order: assert property (is_mode_wr && mode_wr_q < 3'h7 |->
      mode_reg_sel == ORDER[mode_wr_q])
    else $error("mode write out of order");
  a_cal_after_mode: assert property (cmd == sdram_init_pkg::CMD_LONG_CAL
      |-> mode_wr_q == 3'h7)
    else $error("calibration before mode writes");
  a_no_nop_used: assert property (cmd != sdram_init_pkg::CMD_NO_OPERATION)
    else $error("no-operation command issued");
  a_term_ctl_static: assert property (cke |=>
      $stable(termination_control_pin))
    else $error("termination control moved");
  c_cke_rise: cover property ($rose(cke));
  c_long_cal: cover property (cmd == sdram_init_pkg::CMD_LONG_CAL);
  c_last_mode: cover property (is_mode_wr && mode_reg_sel == 3'h0);
endmodule

//--- test/tb_top.sv
// Bench: both ends joined, plus a second device driven by the bench
`timescale 1ns/1ps
module tb_top;
  localparam int RW = 50;
  localparam int SH = 40;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic o_ready;
  logic [17:0] mode_val [7];
  logic [17:0] mode_a [7];
  logic [17:0] mode_b [7];
  logic seen_b;
  logic [1:0] bg_b;
  logic [1:0] ba_b;
  logic [17:0] row_b;
  logic [9:0] col_b;
  logic pre_b;
  logic chop_b;
  sdram_init_pkg::dev_width_t wid = sdram_init_pkg::WIDTH_X8;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  sdram_link_if link ();
  sdram_link_if link_b ();
  sdram_init_ctrl #(.RESET_WAIT_CYC(RW), .SCAN_HOLD_CYC(SH))
    u_sdram_init_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
    .i_mode_val(mode_val), .o_ready(o_ready), .link(link.ctrl));
  sdram_init_dev u_sdram_init_dev (.i_clk(i_clk), .i_rst(i_rst),
    .i_width(sdram_init_pkg::WIDTH_X8), .o_mode_reg(mode_a),
    .o_cke_seen(), .o_act_bg(), .o_act_bank(), .o_act_row(), .o_col(),
    .o_auto_pre(), .o_chop(), .o_burst_active(), .o_beat(),
    .link(link.dev));
  sdram_init_dev u_sdram_init_dev_2 (.i_clk(i_clk), .i_rst(i_rst),
    .i_width(wid), .o_mode_reg(mode_b), .o_cke_seen(seen_b),
    .o_act_bg(bg_b), .o_act_bank(ba_b), .o_act_row(row_b), .o_col(col_b),
    .o_auto_pre(pre_b), .o_chop(chop_b), .o_burst_active(), .o_beat(),
    .link(link_b.dev));
  sdram_link_checker #(.RESET_WAIT_CYC(RW)) u_sdram_link_checker (
    .i_clk(i_clk), .i_rst(i_rst), .reset_n(link.reset_n),
    .cke(link.cke), .termination_control_pin(link.termination_control_pin),
    .cmd(link.cmd), .mode_reg_sel(link.mode_reg_sel),
    .term_hiz(link.term_hiz));
  // ----------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  // Whole run needs about 1300 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk_bit(input logic a, input logic e, input string m);
    total_checks++;
    if (a !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic chk_val(input logic [17:0] a, input logic [17:0] e,
                         input string m);
    total_checks++;
    if (a !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  // One command for one cycle, then deselect; outputs settle after
  task automatic send_b(input sdram_init_pkg::cmd_t c, input logic [1:0] g,
    input logic [1:0] b, input logic [17:0] a, input logic [2:0] s);
    @(posedge i_clk);
    #1;
    link_b.cmd = c;
    link_b.bank_group_select = g;
    link_b.bank_sel = b;
    link_b.addr = a;
    link_b.mode_reg_sel = s;
    @(posedge i_clk);
    #1;
    link_b.cmd = sdram_init_pkg::CMD_DESELECT;
  endtask
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    for (n = 0; n < 7; n++) mode_val[n] = {15'h2a5a, 3'(n)};
    link_b.reset_n = 1'b0;
    link_b.scan_mode_enable_pin = 1'b0;
    link_b.cke = 1'b0;
    link_b.termination_control_pin = 1'b0;
    link_b.cmd = sdram_init_pkg::CMD_DESELECT;
    link_b.bank_group_select = 2'h0;
    link_b.bank_sel = 2'h0;
    link_b.addr = 18'h00000;
    link_b.mode_reg_sel = 3'h0;
    link_b.wdata = 16'h0000;
    repeat (10) tick();
    i_rst = 1'b0;
    chk_bit(link.reset_n, 1'b0, "reset pin");
    chk_bit(link.cke, 1'b0, "cke at reset");
    chk_bit(link.term_hiz, 1'b1, "termination at reset");
    for (n = 0; n < 7; n++) chk_val(mode_a[n], 18'h0, "mode default");
    $display("test reset_defaults done");
    // Full power-up walk; waits are counted, not assumed
    i_start = 1'b1;
    tick();
    i_start = 1'b0;
    for (n = 0; n < 1000 && link.reset_n !== 1'b1; n++) tick();
    chk_bit(n >= SH, 1'b1, "reset low too short");
    chk_bit(link.scan_mode_enable_pin, 1'b0, "scan pin");
    for (n = 0; n < 1000 && link.cke !== 1'b1; n++) tick();
    chk_bit(n >= RW, 1'b1, "cke wait too short");
    chk_bit(link.cke, 1'b1, "init start late");
    for (n = 0; n < 2000 && o_ready !== 1'b1; n++) tick();
    chk_bit(o_ready, 1'b1, "ready");
    chk_bit(link.cke, 1'b1, "cke held");
    chk_val({14'h0, link.cmd}, 18'h0, "idle deselect");
    chk_bit(link.term_hiz, 1'b0, "termination after cke");
    for (n = 0; n < 7; n++) chk_val(mode_a[n], mode_val[n], "mode");
    $display("test power_up done");
    // Second device: termination hold-off, decode, reset defaults
    tick();
    link_b.reset_n = 1'b1;
    tick();
    tick();
    chk_bit(link_b.term_hiz, 1'b1, "termination before cke");
    link_b.cke = 1'b1;
    tick();
    tick();
    chk_bit(seen_b, 1'b1, "cke seen");
    chk_bit(link_b.term_hiz, 1'b0, "termination on");
    send_b(sdram_init_pkg::CMD_ROW_ACTIVATE, 2'h3, 2'h2, 18'h3ffff, 3'h0);
    chk_val({16'h0, bg_b}, 18'h3, "bank group");
    chk_val({16'h0, ba_b}, 18'h2, "bank");
    chk_val(row_b, 18'h3ffff, "row");
    wid = sdram_init_pkg::WIDTH_X16;
    send_b(sdram_init_pkg::CMD_ROW_ACTIVATE, 2'h3, 2'h1, 18'h15555, 3'h0);
    chk_val({16'h0, bg_b}, 18'h1, "x16 bank group");
    send_b(sdram_init_pkg::CMD_READ, 2'h0, 2'h0, 18'h014a5, 3'h0);
    chk_val({8'h0, col_b}, 18'h0a5, "column");
    chk_bit(pre_b, 1'b1, "auto precharge");
    chk_bit(chop_b, 1'b0, "fixed full burst");
    for (n = 0; n < 20 && link_b.rdata_valid === 1'b1; n++) tick();
    chk_val(18'(n), 18'h8, "full burst beats");
    send_b(sdram_init_pkg::CMD_MODE_REG_WRITE, 2'h0, 2'h0, 18'h1, 3'h0);
    send_b(sdram_init_pkg::CMD_WRITE, 2'h0, 2'h0, 18'h0003c, 3'h0);
    chk_bit(pre_b, 1'b0, "no precharge");
    chk_bit(chop_b, 1'b1, "on-the-fly chop");
    for (n = 0; n < 20 && link_b.rdata_valid === 1'b1; n++) tick();
    chk_val(18'(n), 18'h4, "chopped burst beats");
    send_b(sdram_init_pkg::CMD_WRITE, 2'h0, 2'h0, 18'h0103c, 3'h0);
    chk_bit(chop_b, 1'b0, "on-the-fly full");
    send_b(sdram_init_pkg::CMD_MODE_REG_WRITE, 2'h0, 2'h0, 18'h3ffff, 3'h3);
    chk_val(mode_b[3], 18'h3ffff, "mode three");
    link_b.reset_n = 1'b0;
    #1;
    chk_bit(link_b.term_hiz, 1'b1, "termination in reset");
    tick();
    link_b.reset_n = 1'b1;
    tick();
    chk_val(mode_b[3], 18'h0, "mode three default");
    $display("test device_decode done");
    summarize();
  end
endmodule
